//--- cfst_offset_frame.sv
// one downlink channel frame start at k x 256 chips minus LEAD after the reference, modulo the frame
`timescale 1ns/1ps
`default_nettype none
module cfst_offset_frame
  import cfst_pkg::*;
#(
  parameter logic [15:0] LEAD = 16'h0000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [15:0] chipInFrame,
  input  wire logic [7:0]  offsetSteps,
  output logic             frameStart
);
  logic [7:0]  steps;
  logic [23:0] prod;
  logic [15:0] ofs;
  logic [16:0] sum;
  logic [15:0] target;

  // out-of-range settings are clamped to the largest step
  assign steps  = (offsetSteps > CFST_OFS_MAX) ? CFST_OFS_MAX : offsetSteps;
  assign prod   = 24'(steps) * 24'(CFST_OFS_STEP);
  assign ofs    = prod[15:0];
  assign sum    = 17'(ofs) + 17'(CFST_FRAME_CHIPS) - 17'(LEAD);
  assign target = (sum >= 17'(CFST_FRAME_CHIPS)) ?
                  16'(sum - 17'(CFST_FRAME_CHIPS)) : sum[15:0];

  always_ff @(posedge clock) begin
    if (rst) begin
      frameStart <= 1'b0;
    end else begin
      frameStart <= (chipInFrame == target);
    end
  end
endmodule : cfst_offset_frame
`default_nettype wire

//--- cfst_pkg.sv
// constants and carriers for the channel frame and slot timing block
package cfst_pkg;
  localparam int CFST_CNT_W        = 16;
  localparam logic [15:0] CFST_FRAME_CHIPS = 16'h9600; // 38400
  localparam logic [16:0] CFST_SPAN_CHIPS  = 17'h12c00; // 76800, two frames
  localparam logic [15:0] CFST_OFS_STEP    = 16'h0100; // 256
  localparam logic [7:0]  CFST_OFS_MAX     = 8'h95;    // 149
  localparam logic [15:0] CFST_PAGE_LEAD   = 16'h1e00; // 7680
  localparam logic [15:0] CFST_SLOT_CHIPS  = 16'h1400; // 5120
  localparam logic [3:0]  CFST_SLOT_LAST   = 4'he;     // 14
  localparam logic [15:0] CFST_PA_T0       = 16'h1e00; // 7680
  localparam logic [15:0] CFST_PA_T1       = 16'h3200; // 12800
  localparam logic [15:0] CFST_PP_T0       = 16'h3c00; // 15360
  localparam logic [15:0] CFST_PP_T1       = 16'h5000; // 20480
  localparam logic [15:0] CFST_PM_T0       = 16'h3c00; // 15360
  localparam logic [15:0] CFST_PM_T1       = 16'h5000; // 20480
  localparam logic [16:0] CFST_RST_CNT     = 17'h00000;

  typedef struct packed {
    logic frameStart;   // common reference frame start
    logic evenFrame;    // frame start with even frame number
    logic slotStart;    // downlink access slot start
    logic [3:0] slotNum;
  } cfst_ref_t;

  typedef struct packed {
    logic [15:0] preToInd;
    logic [15:0] preToPre;
    logic [15:0] preToMsg;
  } cfst_dist_t;
endpackage : cfst_pkg

//--- cfst_timing.sv
// chip-rate frame, offset and access slot timing generator
`timescale 1ns/1ps
`default_nettype none
module cfst_timing
  import cfst_pkg::*;
#(
  parameter int NUM_SEC = 2,
  parameter int NUM_DED = 2
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  refSync,
  input  wire logic                  evenSfn,
  input  wire logic                  indTiming,
  input  wire logic [NUM_SEC*8-1:0]  secOffset,
  input  wire logic [NUM_DED*8-1:0]  dedOffset,
  input  wire logic [NUM_SEC-1:0]    pageSet,
  input  wire logic                  preambleDet,
  input  wire logic                  collisionDet,
  output cfst_ref_t                  refTiming,
  output logic [NUM_SEC-1:0]         secFrameStart,
  output logic [NUM_SEC-1:0]         pageFrameStart,
  output logic [NUM_SEC-1:0]         pagingMsgFrame,
  output logic [NUM_DED-1:0]         dedFrameStart,
  output cfst_dist_t                 distances,
  output logic                       ackIndStart,
  output logic                       collIndStart
);
  logic [16:0] chipCnt;
  logic [16:0] next_chipCnt;
  logic [15:0] chipInFrame;
  logic [15:0] chipInSlot;
  logic [15:0] next_chipInSlot;
  logic [3:0]  slotIdx;
  logic [3:0]  next_slotIdx;
  logic        wrapSpan;
  logic        lockNow;
  logic [16:0] curCnt;
  logic [15:0] curSlot;
  logic [3:0]  curIdx;
  logic        slotEnd;
  logic [15:0] indDelay;
  logic [15:0] ackCnt;
  logic [15:0] collCnt;
  logic        ackPend;
  logic        collPend;
  logic        ackDue;
  logic        collDue;
  logic [NUM_SEC-1:0] pageHold;
  logic [NUM_SEC-1:0] pageStartW;
  logic [NUM_SEC-1:0] secStartW;

  // reference counter over two frames, re-locked on an even frame sync
  // a lock edge is chip 0 itself, so its frame and slot pulses still fire
  assign lockNow      = refSync && evenSfn;
  assign curCnt       = lockNow ? CFST_RST_CNT : chipCnt;
  assign curSlot      = lockNow ? 16'h0000 : chipInSlot;
  assign curIdx       = lockNow ? 4'h0 : slotIdx;
  assign wrapSpan     = (curCnt == CFST_SPAN_CHIPS - 17'h00001);
  assign next_chipCnt = wrapSpan ? CFST_RST_CNT :
                        curCnt + 17'h00001;
  assign chipInFrame  = (curCnt >= 17'(CFST_FRAME_CHIPS)) ?
                        16'(curCnt - 17'(CFST_FRAME_CHIPS)) : curCnt[15:0];
  assign slotEnd      = (curSlot == CFST_SLOT_CHIPS - 16'h0001);
  assign next_chipInSlot = (slotEnd || wrapSpan) ? 16'h0000 :
                           curSlot + 16'h0001;
  assign next_slotIdx = wrapSpan ? 4'h0 :
                        (slotEnd && curIdx == CFST_SLOT_LAST) ? 4'h0 :
                        slotEnd ? curIdx + 4'h1 : curIdx;

  always_ff @(posedge clock) begin
    if (rst) begin
      chipCnt    <= CFST_RST_CNT;
      chipInSlot <= 16'h0000;
      slotIdx    <= 4'h0;
    end else begin
      chipCnt    <= next_chipCnt;
      chipInSlot <= next_chipInSlot;
      slotIdx    <= next_slotIdx;
    end
  end

  // common frame start for sync, pilot, broadcast and shared channels
  always_ff @(posedge clock) begin
    if (rst) begin
      refTiming <= '0;
    end else begin
      refTiming.frameStart <= (chipInFrame == 16'h0000);
      refTiming.evenFrame  <= (curCnt == CFST_RST_CNT);
      refTiming.slotStart  <= (curSlot == 16'h0000);
      refTiming.slotNum    <= curIdx;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SEC; gi++) begin : g_sec
      cfst_offset_frame #(.LEAD(16'h0000)) u_sec (
        .clock       (clock),
        .rst         (rst),
        .chipInFrame (chipInFrame),
        .offsetSteps (secOffset[gi*8 +: 8]),
        .frameStart  (secStartW[gi])
      );
      cfst_offset_frame #(.LEAD(CFST_PAGE_LEAD)) u_page (
        .clock       (clock),
        .rst         (rst),
        .chipInFrame (chipInFrame),
        .offsetSteps (secOffset[gi*8 +: 8]),
        .frameStart  (pageStartW[gi])
      );
      // page flag sampled at its indicator frame start, served next frame
      always_ff @(posedge clock) begin
        if (rst) begin
          pageHold[gi]       <= 1'b0;
          pagingMsgFrame[gi] <= 1'b0;
        end else begin
          if (pageStartW[gi]) begin
            pageHold[gi] <= pageSet[gi];
          end else if (secStartW[gi]) begin
            pageHold[gi] <= 1'b0;
          end
          pagingMsgFrame[gi] <= secStartW[gi] && pageHold[gi];
        end
      end
    end
    for (gi = 0; gi < NUM_DED; gi++) begin : g_ded
      cfst_offset_frame #(.LEAD(16'h0000)) u_ded (
        .clock       (clock),
        .rst         (rst),
        .chipInFrame (chipInFrame),
        .offsetSteps (dedOffset[gi*8 +: 8]),
        .frameStart  (dedFrameStart[gi])
      );
    end
  endgenerate

  // registered copies keep these outputs aligned with the page flags
  always_ff @(posedge clock) begin
    if (rst) begin
      secFrameStart  <= '0;
      pageFrameStart <= '0;
    end else begin
      secFrameStart  <= secStartW;
      pageFrameStart <= pageStartW;
    end
  end

  // distances chosen by the indicator timing setting
  assign indDelay = indTiming ? CFST_PA_T1 : CFST_PA_T0;

  always_ff @(posedge clock) begin
    if (rst) begin
      distances <= '0;
    end else begin
      distances.preToInd <= indTiming ? CFST_PA_T1 : CFST_PA_T0;
      distances.preToPre <= indTiming ? CFST_PP_T1 : CFST_PP_T0;
      distances.preToMsg <= indTiming ? CFST_PM_T1 : CFST_PM_T0;
    end
  end

  // preamble detections arrive at uplink slot starts, so the delayed
  // indicator lands on a downlink slot boundary
  assign ackDue  = ackPend && (ackCnt == indDelay - 16'h0001);
  assign collDue = collPend && (collCnt == indDelay - 16'h0001);

  always_ff @(posedge clock) begin
    if (rst) begin
      ackPend     <= 1'b0;
      ackCnt      <= 16'h0000;
      ackIndStart <= 1'b0;
    end else begin
      if (preambleDet) begin
        ackPend <= 1'b1;
        ackCnt  <= 16'h0000;
      end else if (ackDue) begin
        ackPend <= 1'b0;
      end else if (ackPend) begin
        ackCnt <= ackCnt + 16'h0001;
      end
      ackIndStart <= ackDue && (curSlot == 16'h0000);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      collPend     <= 1'b0;
      collCnt      <= 16'h0000;
      collIndStart <= 1'b0;
    end else begin
      if (collisionDet) begin
        collPend <= 1'b1;
        collCnt  <= 16'h0000;
      end else if (collDue) begin
        collPend <= 1'b0;
      end else if (collPend) begin
        collCnt <= collCnt + 16'h0001;
      end
      collIndStart <= collDue && (curSlot == 16'h0000);
    end
  end

  a_slot_length: assert property (@(posedge clock) disable iff (rst)
    (refTiming.slotStart && !$past(refSync)) |=>
      !refTiming.slotStart [*8])
    else $error("slot start repeated too soon");

  a_frame_common: assert property (@(posedge clock) disable iff (rst)
    refTiming.evenFrame |-> refTiming.frameStart && refTiming.slotStart
      && refTiming.slotNum == 4'h0)
    else $error("even frame not aligned to slot zero");

  a_ind_on_slot: assert property (@(posedge clock) disable iff (rst)
    (ackIndStart || collIndStart) |-> refTiming.slotStart)
    else $error("indicator started mid slot");

  a_dist_select: assert property (@(posedge clock) disable iff (rst)
    (!$past(rst) && $past(indTiming)) |-> distances.preToInd == 16'h3200
      && distances.preToPre == 16'h5000)
    else $error("setting one distances wrong");

  a_dist_zero: assert property (@(posedge clock) disable iff (rst)
    (!$past(rst) && !$past(indTiming)) |-> distances.preToInd == 16'h1e00
      && distances.preToMsg == 16'h3c00)
    else $error("setting zero distances wrong");

  a_counter_wrap: assert property (@(posedge clock) disable iff (rst)
    (wrapSpan && !(refSync && evenSfn)) |=> chipCnt == 17'h00000)
    else $error("chip counter did not wrap");

  a_page_serve: assert property (@(posedge clock) disable iff (rst)
    pagingMsgFrame[0] |-> secFrameStart[0])
    else $error("paging outside a secondary frame start");

  a_page_lead: assert property (@(posedge clock) disable iff (rst)
    (pageFrameStart[0] && !refSync) |-> !secFrameStart[0])
    else $error("page frame coincides with its secondary frame");
endmodule : cfst_timing
`default_nettype wire

//--- cfst_timing_test.sv
// self-checking bench for the frame and access slot timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (e)); end end
`define FIRST(s, t) if (t0 != 0 && (s) === 1'b1 && t == 0) t = cyc;
module cfst_timing_test
  import cfst_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       refSync = 1'b0;
  logic       evenSfn = 1'b0;
  logic       indTiming = 1'b0;
  logic [15:0] secOffset = 16'h0095;
  logic [15:0] dedOffset = 16'hc800;
  logic [1:0] pageSet = 2'b01;
  logic       preambleDet;
  logic       collisionDet;
  cfst_ref_t  refTiming;
  cfst_dist_t distances;
  logic [1:0] secFrameStart;
  logic [1:0] pageFrameStart;
  logic [1:0] pagingMsgFrame;
  logic [1:0] dedFrameStart;
  logic       ackIndStart;
  logic       collIndStart;
  int err_count, cmp_count, cyc, t0, n;
  int tSec0, tSec1, tPg0, tPg1, tDed0, tDed1, tMsg0, nMsg1;
  int tPre, tAck, tCd, tColl, nAck, nFrame, nEven, nSlot;
  bit win, locked;
  cfst_timing #(.NUM_SEC(2), .NUM_DED(2)) uut (
    .clock(clock), .rst(rst), .refSync(refSync), .evenSfn(evenSfn),
    .indTiming(indTiming), .secOffset(secOffset), .dedOffset(dedOffset),
    .pageSet(pageSet), .preambleDet(preambleDet),
    .collisionDet(collisionDet), .refTiming(refTiming),
    .secFrameStart(secFrameStart), .pageFrameStart(pageFrameStart),
    .pagingMsgFrame(pagingMsgFrame), .dedFrameStart(dedFrameStart),
    .distances(distances), .ackIndStart(ackIndStart),
    .collIndStart(collIndStart)
  );
  cfst_ue_model ue (
    .clock(clock), .slotStart(refTiming.slotStart),
    .distances(distances), .preambleDet(preambleDet),
    .collisionDet(collisionDet)
  );
  always #12.5 clock = ~clock;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // event log in cycles, relative to the first reference frame start after the lock
  always @(posedge clock) begin
    if (cyc == 100000) begin
      err_count++;
      report_and_stop();
    end
    if (locked && refTiming.frameStart === 1'b1 && t0 == 0) t0 = cyc;
    win = t0 != 0 && cyc - t0 <= 76800;
    `FIRST(secFrameStart[0], tSec0)
    `FIRST(secFrameStart[1], tSec1)
    `FIRST(pageFrameStart[0], tPg0)
    `FIRST(pageFrameStart[1], tPg1)
    `FIRST(dedFrameStart[0], tDed0)
    `FIRST(dedFrameStart[1], tDed1)
    `FIRST(pagingMsgFrame[0], tMsg0)
    if (pagingMsgFrame[1] === 1'b1) nMsg1++;
    if (preambleDet === 1'b1) tPre = cyc;
    if (collisionDet === 1'b1) tCd = cyc;
    if (ackIndStart === 1'b1) begin
      tAck = cyc;
      nAck++;
      `CHK(refTiming.slotStart, 1'b1)
    end
    if (collIndStart === 1'b1) begin
      tColl = cyc;
      `CHK(refTiming.slotStart, 1'b1)
    end
    if (win && refTiming.frameStart === 1'b1) nFrame++;
    if (win && refTiming.evenFrame === 1'b1) begin
      nEven++;
      `CHK(refTiming.slotNum, 4'h0)
    end
    if (win && refTiming.slotStart === 1'b1) begin
      nSlot++;
      `CHK((cyc - t0) % 5120, 0)
      `CHK(refTiming.slotNum, 4'(((cyc - t0) / 5120) % 15))
    end
    cyc++;
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (100) @(negedge clock);
    n = cyc;
    locked = 1'b1;
    refSync = 1'b1;
    evenSfn = 1'b1;
    @(negedge clock);
    refSync = 1'b0;
    evenSfn = 1'b0;
    `CHK(distances.preToInd, 16'h1e00)
    `CHK(distances.preToPre, 16'h3c00)
    `CHK(distances.preToMsg, 16'h3c00)
    // a sync without the even flag must not move the counter
    @(negedge clock);
    refSync = 1'b1;
    @(negedge clock);
    refSync = 1'b0;
    `CHK(t0 - n, 1)
    ue.packet_access();
    repeat (7700) @(negedge clock);
    `CHK(tAck - tPre, 7681)
    `CHK(tColl - tCd, 7681)
    n = nAck;
    ue.preamble(1);
    repeat (7700) @(negedge clock);
    `CHK(nAck, n)
    indTiming = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(distances.preToInd, 16'h3200)
    `CHK(distances.preToPre, 16'h5000)
    `CHK(distances.preToMsg, 16'h5000)
    ue.packet_access();
    repeat (12820) @(negedge clock);
    `CHK(tAck - tPre, 12801)
    `CHK(tColl - tCd, 12801)
    while (cyc <= t0 + 76802) @(negedge clock);
    `CHK(tDed0 - t0, 0)
    `CHK(tDed1 - t0, 38144)
    `CHK(tSec0 - t0, 38145)
    `CHK(tSec1 - t0, 1)
    `CHK(tPg0 - t0, 30465)
    `CHK(tPg1 - t0, 30721)
    `CHK(tMsg0, tSec0)
    `CHK(nMsg1, 0)
    `CHK(nFrame, 3)
    `CHK(nEven, 2)
    `CHK(nSlot, 16)
    report_and_stop();
  end
endmodule : cfst_timing_test
`default_nettype wire

//--- cfst_ue_model.sv
// terminal model sending access and collision preambles at uplink slots
`timescale 1ns/1ps
`default_nettype none
module cfst_ue_model
  import cfst_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       slotStart,
  input  wire cfst_dist_t distances,
  output logic            preambleDet,
  output logic            collisionDet
);
  initial begin
    preambleDet  = 1'b0;
    collisionDet = 1'b0;
  end
  task automatic pulse(input bit coll);
    if (coll) collisionDet = 1'b1;
    else preambleDet = 1'b1;
    @(negedge clock);
    preambleDet  = 1'b0;
    collisionDet = 1'b0;
  endtask : pulse
  // uplink slot leads the downlink slot by half a slot; skew is misuse
  task automatic preamble(input int skew);
    @(negedge clock);
    while (slotStart !== 1'b1) @(negedge clock);
    repeat (2559 + skew) @(negedge clock);
    pulse(1'b0);
  endtask : preamble
  // one access preamble per call; spacing between calls is set only by the caller and is not held to preToPre
  task automatic packet_access();
    preamble(0);
    repeat (int'(distances.preToMsg) - 1) @(negedge clock);
    pulse(1'b1);
  endtask : packet_access
endmodule : cfst_ue_model
`default_nettype wire
